// ---- rtl/aitr_mode_field.sv ----
// One three-bit mode field, forced to zero when its code is reserved.
// Assumes a static legal maximum per field.
`timescale 1ns/1ps
`default_nettype none
module aitr_mode_field #(
  parameter logic [2:0] MAXV = 3'h2
) (
  input wire logic [2:0] rawMode,
  output logic [2:0] cleanMode
);
  // Reserved codes would mislead the host; report the safe default
  assign cleanMode = (rawMode > MAXV) ? 3'h0 : rawMode;
endmodule : aitr_mode_field
`default_nettype wire

// ---- rtl/aitr_pkg.sv ----
// Constants, types and command codes of the idle and timing-report block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package aitr_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_IDLE_A = 8'h97;
  localparam logic [7:0] OP_IDLE_B = 8'hE3;
  localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] OP_IDLE_IMM_B = 8'hE1;
  localparam logic [7:0] OP_INIT_PARAMS = 8'h91;

  // ----------------------------------------------------------------
  // Field positions and legal maxima
  // ----------------------------------------------------------------
  localparam int FLD_LO0 = 0;
  localparam int FLD_LO1 = 3;
  localparam int FLD_LO2 = 6;
  localparam int FLD_LO3 = 9;
  localparam int FLD_LO4 = 12;
  localparam int W164_VALID_BIT = 15;
  localparam logic [2:0] MAX_ADV_MODE = 3'h2;
  localparam logic [2:0] MAX_CYCLE_MODE = 3'h3;
  localparam logic [2:0] MAX_UDMA_MODE = 3'h6;
  localparam logic [3:0] W163_RESERVED = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PD_UNIT_NS = 5000000;
  localparam int PD_UNIT_CYCLES = PD_UNIT_NS / CLK_PERIOD_NS;
  localparam int DEF_SLEEP_MS = 20;
  localparam int PD_UNIT_MS = 5;
  localparam logic [7:0] DEF_SLEEP_TICKS = 8'(DEF_SLEEP_MS / PD_UNIT_MS);
  localparam int TIMER_W = 20;

  // ----------------------------------------------------------------
  // Reset values and states
  // ----------------------------------------------------------------
  localparam logic [7:0] SPT_RESET = 8'h00;
  localparam logic [4:0] HEADS_RESET = 5'h01;

  typedef enum logic [1:0] {
    CMD_READY = 2'b00,
    CMD_BUSY = 2'b01,
    CMD_DONE = 2'b10
  } aitr_cmd_e;

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_IDLE = 2'b01,
    PM_SLEEP = 2'b10
  } aitr_pm_e;

endpackage : aitr_pkg

// ---- rtl/aitr_tick_if.sv ----
// Restart and tick between the power-down time base and its user.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface aitr_tick_if;
  logic restart;
  logic tick;
  modport timer (input restart, output tick);
  modport user (output restart, input tick);
endinterface : aitr_tick_if
`default_nettype wire

// ---- rtl/aitr_tick_timer.sv ----
// Free-running time base giving one tick per period, restartable.
// Assumes restart is a one-cycle pulse from the command logic.
`timescale 1ns/1ps
`default_nettype none
module aitr_tick_timer #(
  parameter int unsigned PERIOD = 100000
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  aitr_tick_if.timer tb
);
  logic [aitr_pkg::TIMER_W-1:0] cnt_r;
  logic tick_r;
  wire atEnd = (cnt_r == aitr_pkg::TIMER_W'(PERIOD - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst || tb.restart || atEnd) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + aitr_pkg::TIMER_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= atEnd && !tb.restart;
    end
  end

  assign tb.tick = tick_r;
endmodule : aitr_tick_timer
`default_nettype wire

// ---- rtl/ata_idle_timing_report.sv ----
// Identify words 163/164 and the Idle, Idle Immediate and Initialize
// Drive Parameters commands. Assumes task-file values are stable with
// cmdValid, a one-cycle pulse, all synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ata_idle_timing_report #(
  parameter int unsigned PD_UNIT_CYC = aitr_pkg::PD_UNIT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdCode,
  input wire logic [7:0] secCount,
  input wire logic [7:0] drvHead,
  input wire logic [2:0] advPioSup,
  input wire logic [2:0] advMdmaSup,
  input wire logic [2:0] advPioSel,
  input wire logic [2:0] advMdmaSel,
  input wire logic [2:0] ioCycleSup,
  input wire logic [2:0] memCycleSup,
  input wire logic [2:0] ioUdmaSup,
  input wire logic [2:0] memUdmaSup,
  input wire logic [2:0] udmaSel,
  input wire logic advModesOk,
  output logic [15:0] identWord163,
  output logic [15:0] identWord164,
  output logic busy,
  output logic intrq,
  output logic idleMode,
  output logic sleeping,
  output logic autoPdEn,
  output logic [7:0] pdLimit,
  output logic [7:0] secPerTrack,
  output logic [4:0] headsPerCyl
);

  // ----------------------------------------------------------------
  // Identify fields
  // ----------------------------------------------------------------
  logic [2:0] fPioSup, fMdmaSup, fPioSel, fMdmaSel;
  logic [2:0] fIoCyc, fMemCyc, fIoUdma, fMemUdma, fUdmaSel;
  logic [15:0] word163_r, word164_r;

  aitr_mode_field #(.MAXV(aitr_pkg::MAX_ADV_MODE)) u_pioSup (
    .rawMode(advPioSup), .cleanMode(fPioSup));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_ADV_MODE)) u_mdmaSup (
    .rawMode(advMdmaSup), .cleanMode(fMdmaSup));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_ADV_MODE)) u_pioSel (
    .rawMode(advPioSel), .cleanMode(fPioSel));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_ADV_MODE)) u_mdmaSel (
    .rawMode(advMdmaSel), .cleanMode(fMdmaSel));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_CYCLE_MODE)) u_ioCyc (
    .rawMode(ioCycleSup), .cleanMode(fIoCyc));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_CYCLE_MODE)) u_memCyc (
    .rawMode(memCycleSup), .cleanMode(fMemCyc));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_UDMA_MODE)) u_ioUdma (
    .rawMode(ioUdmaSup), .cleanMode(fIoUdma));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_UDMA_MODE)) u_memUdma (
    .rawMode(memUdmaSup), .cleanMode(fMemUdma));
  aitr_mode_field #(.MAXV(aitr_pkg::MAX_UDMA_MODE)) u_udmaSel (
    .rawMode(udmaSel), .cleanMode(fUdmaSel));

  // UDMA maxima mean nothing without the valid bit, so they read zero then
  wire [2:0] ioUdmaRep = advModesOk ? fIoUdma : 3'h0;
  wire [2:0] memUdmaRep = advModesOk ? fMemUdma : 3'h0;
  wire [15:0] word163_nxt = {aitr_pkg::W163_RESERVED, fMdmaSel, fPioSel,
                             fMdmaSup, fPioSup};
  wire [15:0] word164_nxt = {advModesOk, fUdmaSel, memUdmaRep, ioUdmaRep,
                             fMemCyc, fIoCyc};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      word163_r <= 16'h0000;
      word164_r <= 16'h0000;
    end else begin
      word163_r <= word163_nxt;
      word164_r <= word164_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  aitr_pkg::aitr_cmd_e cmdState_r;
  logic [7:0] opCode_r;
  logic [7:0] opCount_r;
  logic [3:0] opHeads_r;

  wire isIdle = (cmdCode == aitr_pkg::OP_IDLE_A) || (cmdCode == aitr_pkg::OP_IDLE_B);
  wire isIdleImm = (cmdCode == aitr_pkg::OP_IDLE_IMM_A) ||
                   (cmdCode == aitr_pkg::OP_IDLE_IMM_B);
  wire isInit = (cmdCode == aitr_pkg::OP_INIT_PARAMS);
  wire known = isIdle || isIdleImm || isInit;
  wire accept = cmdValid && known && (cmdState_r == aitr_pkg::CMD_READY);
  wire execIdle = (cmdState_r == aitr_pkg::CMD_BUSY) &&
                  ((opCode_r == aitr_pkg::OP_IDLE_A) || (opCode_r == aitr_pkg::OP_IDLE_B));
  wire execIdleImm = (cmdState_r == aitr_pkg::CMD_BUSY) &&
                     ((opCode_r == aitr_pkg::OP_IDLE_IMM_A) ||
                      (opCode_r == aitr_pkg::OP_IDLE_IMM_B));
  wire execInit = (cmdState_r == aitr_pkg::CMD_BUSY) &&
                  (opCode_r == aitr_pkg::OP_INIT_PARAMS);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opCode_r <= 8'h00;
      opCount_r <= 8'h00;
      opHeads_r <= 4'h0;
    end else if (accept) begin
      opCode_r <= cmdCode;
      opCount_r <= secCount;
      opHeads_r <= drvHead[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer: busy, execute, release busy with interrupt
  // ----------------------------------------------------------------
  aitr_pkg::aitr_cmd_e cmdState_nxt;
  always_comb begin
    case (cmdState_r)
      aitr_pkg::CMD_READY: cmdState_nxt = accept ? aitr_pkg::CMD_BUSY : aitr_pkg::CMD_READY;
      aitr_pkg::CMD_BUSY: cmdState_nxt = aitr_pkg::CMD_DONE;
      aitr_pkg::CMD_DONE: cmdState_nxt = aitr_pkg::CMD_READY;
      default: cmdState_nxt = aitr_pkg::CMD_READY;
    endcase
  end

  logic busy_r, intrq_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmdState_r <= aitr_pkg::CMD_READY;
      busy_r <= 1'b0;
      intrq_r <= 1'b0;
    end else begin
      cmdState_r <= cmdState_nxt;
      busy_r <= (cmdState_nxt == aitr_pkg::CMD_BUSY);
      intrq_r <= (cmdState_nxt == aitr_pkg::CMD_DONE);
    end
  end

  // ----------------------------------------------------------------
  // Drive geometry
  // ----------------------------------------------------------------
  logic [7:0] spt_r;
  logic [4:0] heads_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spt_r <= aitr_pkg::SPT_RESET;
      heads_r <= aitr_pkg::HEADS_RESET;
    end else if (execInit) begin
      spt_r <= opCount_r;
      heads_r <= {1'b0, opHeads_r} + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Power management
  // ----------------------------------------------------------------
  aitr_tick_if tickBus ();
  aitr_tick_timer #(.PERIOD(PD_UNIT_CYC)) u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tb(tickBus)
  );
  assign tickBus.restart = cmdValid;

  aitr_pkg::aitr_pm_e pmState_r;
  logic idleSeen_r, autoPd_r;
  logic [7:0] limit_r;
  logic [7:0] idleTicks_r;

  // Before any Idle the fixed 20 ms applies, afterwards the host's choice
  wire [7:0] target = idleSeen_r ? limit_r : aitr_pkg::DEF_SLEEP_TICKS;
  wire armed = !idleSeen_r || autoPd_r;
  wire [8:0] ticksAfter = {1'b0, idleTicks_r} + 9'h001;
  wire expire = tickBus.tick && armed && (ticksAfter >= {1'b0, target}) &&
                (cmdState_r == aitr_pkg::CMD_READY) && !cmdValid;

  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmdValid) begin
      idleTicks_r <= 8'h00;
    end else if (tickBus.tick && idleTicks_r != 8'hFF) begin
      idleTicks_r <= idleTicks_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idleSeen_r <= 1'b0;
      autoPd_r <= 1'b0;
      limit_r <= 8'h00;
    end else if (execIdle) begin
      idleSeen_r <= 1'b1;
      autoPd_r <= (opCount_r != 8'h00);
      limit_r <= opCount_r;
    end
  end

  aitr_pkg::aitr_pm_e pmState_nxt;
  always_comb begin
    case (pmState_r)
      aitr_pkg::PM_ACTIVE, aitr_pkg::PM_IDLE: begin
        if (execIdle || execIdleImm) begin
          pmState_nxt = aitr_pkg::PM_IDLE;
        end else if (expire) begin
          pmState_nxt = aitr_pkg::PM_SLEEP;
        end else begin
          pmState_nxt = pmState_r;
        end
      end
      aitr_pkg::PM_SLEEP: pmState_nxt = cmdValid ? aitr_pkg::PM_ACTIVE : aitr_pkg::PM_SLEEP;
      default: pmState_nxt = aitr_pkg::PM_ACTIVE;
    endcase
  end

  // Power outputs come from their own flops, not from a state decode
  logic idleMode_r, sleeping_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pmState_r <= aitr_pkg::PM_ACTIVE;
      idleMode_r <= 1'b0;
      sleeping_r <= 1'b0;
    end else begin
      pmState_r <= pmState_nxt;
      idleMode_r <= (pmState_nxt == aitr_pkg::PM_IDLE);
      sleeping_r <= (pmState_nxt == aitr_pkg::PM_SLEEP);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign identWord163 = word163_r;
  assign identWord164 = word164_r;
  assign busy = busy_r;
  assign intrq = intrq_r;
  assign idleMode = idleMode_r;
  assign sleeping = sleeping_r;
  assign autoPdEn = autoPd_r;
  assign pdLimit = limit_r;
  assign secPerTrack = spt_r;
  assign headsPerCyl = heads_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_busyPhase;
    busy && !intrq;
  endsequence

  sequence s_release;
    !busy && intrq;
  endsequence

  chk_word163_reserved: assert property (
    identWord163[15:12] == 4'h0) else $error("word 163 reserved bits set");

  chk_adv_fields: assert property (
    identWord163[2:0] <= 3'h2 && identWord163[8:6] <= 3'h2 &&
    ($past(sys_rst) || $past(advPioSup) > 3'h2 || identWord163[2:0] == $past(advPioSup)))
    else $error("advanced PIO field wrong");

  chk_mdma_fields: assert property (
    identWord163[5:3] <= 3'h2 && identWord163[11:9] <= 3'h2 &&
    ($past(sys_rst) || $past(advMdmaSel) > 3'h2 || identWord163[11:9] == $past(advMdmaSel)))
    else $error("multiword DMA field wrong");

  chk_mdma_support: assert property (
    $past(sys_rst) || $past(advMdmaSup) > 3'h2 || identWord163[5:3] == $past(advMdmaSup))
    else $error("multiword DMA support field wrong");

  chk_pio_select: assert property (
    $past(sys_rst) || $past(advPioSel) > 3'h2 || identWord163[8:6] == $past(advPioSel))
    else $error("PIO selected field wrong");

  chk_mem_cycle: assert property (
    $past(sys_rst) || $past(memCycleSup) > 3'h3 || identWord164[5:3] == $past(memCycleSup))
    else $error("memory cycle field wrong");

  chk_mem_udma: assert property (
    $past(sys_rst) || !$past(advModesOk) || $past(memUdmaSup) == 3'h7 ||
      identWord164[11:9] == $past(memUdmaSup))
    else $error("memory UDMA field wrong");

  chk_cycle_fields: assert property (
    identWord164[2:0] <= 3'h3 && identWord164[5:3] <= 3'h3)
    else $error("cycle time field reserved");

  chk_udma_gated: assert property (
    !identWord164[15] |-> identWord164[11:6] == 6'h00)
    else $error("UDMA maxima shown without valid bit");

  chk_udma_sel: assert property (
    identWord164[14:12] != 3'h7 && identWord164[8:6] != 3'h7)
    else $error("UDMA field reserved");

  chk_valid_bit: assert property (
    $past(sys_rst) || identWord164[15] == $past(advModesOk))
    else $error("word 164 bit 15 stale");

  chk_busy_then_irq: assert property (
    busy |=> !busy && intrq) else $error("busy not followed by interrupt");

  chk_auto_off: assert property (
    (idleSeen_r && !autoPdEn && !sleeping) |=> !sleeping)
    else $error("slept with auto power-down off");

  chk_timer_restart: assert property (
    cmdValid |=> idleTicks_r == 8'h00) else $error("power-down count not restarted");

  chk_idle_sequence: assert property (
    (cmdValid && isIdle && !busy && !intrq) |-> ##1 s_busyPhase ##1 (s_release and idleMode))
    else $error("Idle sequence wrong");

  chk_idle_imm_keep: assert property (
    (cmdValid && isIdleImm && !busy && !intrq) |->
      ##1 s_busyPhase ##1 (s_release and idleMode && autoPdEn == $past(autoPdEn, 2)))
    else $error("Idle Immediate sequence wrong");

  chk_idle_timer_load: assert property (
    (accept && isIdle && secCount != 8'h00) |->
      ##2 (autoPdEn && pdLimit == $past(secCount, 2)))
    else $error("Idle timer not loaded");

  chk_idle_zero: assert property (
    (accept && isIdle && secCount == 8'h00) |-> ##2 !autoPdEn)
    else $error("auto power-down not disabled");

  chk_sleep_cause: assert property (
    $rose(sleeping) |-> $past(tickBus.tick) &&
      ({1'b0, $past(idleTicks_r)} + 9'h001 >= {1'b0, $past(target)}))
    else $error("sleep entered early");

  chk_init_params: assert property (
    (accept && isInit) |-> ##2 (secPerTrack == $past(secCount, 2) &&
      headsPerCyl == {1'b0, $past(drvHead[3:0], 2)} + 5'h01))
    else $error("drive parameters not stored");

  chk_wake_on_cmd: assert property (
    (sleeping && cmdValid) |-> ##1 (!sleeping && idleTicks_r == 8'h00))
    else $error("no wake on command");

endmodule : ata_idle_timing_report
`default_nettype wire

// ---- sim/aitr_host_model.sv ----
// Host controller model: writes one task-file command per request.
// Assumes it shares sys_clk with the block and never issues while busy.
`timescale 1ns/1ps
`default_nettype none
module aitr_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] opCode,
  input wire logic [7:0] count,
  input wire logic [4:0] heads,
  input wire logic busy,
  input wire logic intrq,
  output logic cmdValid,
  output logic [7:0] cmdCode,
  output logic [7:0] secCount,
  output logic [7:0] drvHead
);
  initial begin
    cmdValid = 1'h0;
    cmdCode = 8'h00;
    secCount = 8'h00;
    drvHead = 8'h00;
  end

  // Unused bits set so a block that reads them shows it
  always @(posedge sys_clk) begin
    if (go && !busy && !intrq && !cmdValid) begin
      cmdValid <= 1'h1;
      cmdCode <= opCode;
      secCount <= count;
      drvHead <= {4'hF, 4'(heads - 5'h01)};
    end else begin
      // Stale task file toggles, never a stable leftover
      cmdValid <= 1'h0;
      cmdCode <= ~cmdCode;
      secCount <= ~secCount;
      drvHead <= ~drvHead;
    end
  end
endmodule : aitr_host_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the identify words and idle commands.
// Assumes a shortened power-down unit of 20 clock cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
  begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  // ------------------------------------------------------------
  // Signals and table
  // ------------------------------------------------------------
  localparam int UNIT = 20;
  typedef struct packed {
    logic [2:0] pioSup, mdmaSup, pioSel, mdmaSel, ioCyc, memCyc, ioU, memU, uSel;
    logic ok;
    logic [15:0] w163, w164;
  } aitr_row_s;
  aitr_row_s rows [5] = '{
    '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 1'h0, 16'h0000, 16'h0000},
    '{3'h2, 3'h2, 3'h1, 3'h2, 3'h3, 3'h3, 3'h6, 3'h6, 3'h6, 1'h1, 16'h0452, 16'hED9B},
    '{3'h3, 3'h7, 3'h5, 3'h4, 3'h4, 3'h7, 3'h7, 3'h7, 3'h7, 1'h1, 16'h0000, 16'h8000},
    '{3'h1, 3'h1, 3'h0, 3'h0, 3'h1, 3'h2, 3'h5, 3'h4, 3'h3, 1'h0, 16'h0009, 16'h3011},
    '{3'h0, 3'h0, 3'h2, 3'h1, 3'h2, 3'h1, 3'h5, 3'h4, 3'h0, 1'h1, 16'h0280, 16'h894A}};
  aitr_row_s cur;
  logic sys_clk, sys_rst, go, cmdValid;
  logic [7:0] opCode, count, cmdCode, secCount, drvHead, pdLimit, secPerTrack;
  logic [4:0] heads, headsPerCyl;
  logic busy, intrq, idleMode, sleeping, autoPdEn;
  logic [15:0] w163, w164;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  aitr_host_model host (.sys_clk(sys_clk), .go(go), .opCode(opCode), .count(count),
    .heads(heads), .busy(busy), .intrq(intrq), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .secCount(secCount), .drvHead(drvHead));

  ata_idle_timing_report #(.PD_UNIT_CYC(UNIT)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .secCount(secCount), .drvHead(drvHead),
    .advPioSup(cur.pioSup), .advMdmaSup(cur.mdmaSup), .advPioSel(cur.pioSel),
    .advMdmaSel(cur.mdmaSel), .ioCycleSup(cur.ioCyc), .memCycleSup(cur.memCyc),
    .ioUdmaSup(cur.ioU), .memUdmaSup(cur.memU), .udmaSel(cur.uSel), .advModesOk(cur.ok),
    .identWord163(w163), .identWord164(w164), .busy(busy), .intrq(intrq),
    .idleMode(idleMode), .sleeping(sleeping), .autoPdEn(autoPdEn), .pdLimit(pdLimit),
    .secPerTrack(secPerTrack), .headsPerCyl(headsPerCyl));

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run is under a thousand cycles; three times that means a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'h1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'h0;
    @(negedge sys_clk);
  endtask : do_reset

  task automatic quiet(input int n, input logic exp);
    repeat (n) @(negedge sys_clk);
    `CHECK(sleeping, exp)
  endtask : quiet

  // Issues one command; run says whether the block must execute it
  task automatic cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [4:0] hd,
      input logic run);
    @(posedge sys_clk);
    go <= 1'h1;
    opCode <= op;
    count <= cnt;
    heads <= hd;
    @(posedge sys_clk);
    go <= 1'h0;
    repeat (2) @(negedge sys_clk);
    `CHECK({busy, intrq}, {run, 1'h0})
    @(negedge sys_clk);
    `CHECK({busy, intrq}, {1'h0, run})
    @(negedge sys_clk);
    `CHECK(intrq, 1'h0)
  endtask : cmd

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    go = 1'h0;
    opCode = 8'h00;
    count = 8'h00;
    heads = 5'h01;
    cur = '0;
    do_reset();
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      cur <= rows[i];
      repeat (3) @(negedge sys_clk);
      `CHECK(w163, rows[i].w163)
      `CHECK(w164, rows[i].w164)
    end
    $display("test identify words done");
    do_reset();
    `CHECK({busy, intrq, idleMode, sleeping, autoPdEn}, 5'h00)
    `CHECK({pdLimit, secPerTrack, headsPerCyl}, 21'h000001)
    quiet(4 * UNIT - 6, 1'h0);
    quiet(12, 1'h1);
    $display("test default sleep done");
    cmd(8'h95, 8'h07, 5'h01, 1'h1);
    `CHECK({sleeping, idleMode, autoPdEn, pdLimit}, 11'h200)
    cmd(8'hE1, 8'h00, 5'h01, 1'h1);
    `CHECK(idleMode, 1'h1)
    $display("test idle immediate done");
    cmd(8'h97, 8'h02, 5'h01, 1'h1);
    `CHECK({idleMode, autoPdEn, pdLimit}, 10'h302)
    quiet(2 * UNIT - 10, 1'h0);
    quiet(14, 1'h1);
    $display("test idle timer done");
    cmd(8'hEC, 8'h00, 5'h01, 1'h0);
    `CHECK({sleeping, autoPdEn, pdLimit}, 10'h102)
    quiet(2 * UNIT - 10, 1'h0);
    quiet(14, 1'h1);
    $display("test refused wake done");
    cmd(8'hE3, 8'h00, 5'h01, 1'h1);
    `CHECK({sleeping, autoPdEn}, 2'h0)
    quiet(6 * UNIT, 1'h0);
    $display("test no auto power down done");
    cmd(8'h91, 8'h3F, 5'h10, 1'h1);
    `CHECK({secPerTrack, headsPerCyl}, 13'h07F0)
    cmd(8'h91, 8'hFF, 5'h01, 1'h1);
    `CHECK({secPerTrack, headsPerCyl}, 13'h1FE1)
    $display("test drive parameters done");
    results();
  end
endmodule : testbench
`default_nettype wire
